// ### ppm_pkg.sv
// holds the constants of the power-path mode controller
// assumes one 10 MHz clock and a synchronous active-high reset
// Behaviour
// [RL1] bus present, chip supply low: batteryless start
// [RL2] batteryless start closes high-voltage sink path
// [RL3] batteryless overvoltage level fixed at 6.8V
// [RL4] leave only on bit write with supply valid; code also leaves with chip supply valid and bus supply gone
// [RL5] bit write with bad supply: stay, flag, alert
// [RL6] batteryless start refuses source and fast swap
// [RL7] registers accessible; only leave bit acts
// [RL8] leaving restores defaults except flags; pins rule
// [RL9] host raises sink request 50us before leaving
// [RL10] zero write to leave bit after exit ignored
// [RL11] supply loss returns to batteryless, clears bit
// [RL12] normal mode when supply valid or after exit
// [RL13] sink request alone closes high-voltage sink
// [RL14] source request alone closes five-volt source
// [RL15] choice bit selects high-voltage source path instead
// [RL16] both requests: error flag, keep switch state
// [RL17] fast swap turns five-volt path on quickly
// [RL18] alerts reported on open-drain output
// [RL19] all enables low: standby, bus logic alive
// [RL20] chip disable high: shutdown regardless of requests
// [RL21] alert held low while any flag set
package ppm_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SRC_CHOICE  = 8'h02;
    localparam logic [7:0] ADDR_INT_FLAGS_A = 8'h04;
    localparam logic [7:0] ADDR_EXIT_SWAP   = 8'h0b;
    localparam int         BIT_SRC_CHOICE   = 0;
    localparam int         BIT_LEAVE_FAULT  = 0;
    localparam int         BIT_FORBID_ERR   = 1;
    localparam int         BIT_LEAVE        = 0;
    localparam int         BIT_SWAP_ARM     = 1;
    localparam logic [7:0] RST_SRC_CHOICE   = 8'h00;
    localparam logic [7:0] RST_EXIT_SWAP    = 8'h00;
    localparam logic [7:0] RST_INT_FLAGS    = 8'h00;
    // overvoltage lockout codes, 6.8V is the fixed batteryless level
    localparam logic [2:0] OVERVOLTAGE_LOCKOUT_CODE_6V8    = 3'h1;
    localparam logic [2:0] RST_OVERVOLTAGE_LOCKOUT_CODE    = 3'h1;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS          = 100;
    localparam int SWAP_LIMIT_NS   = 100000;
    localparam int SWAP_LIMIT_CYC  = SWAP_LIMIT_NS / CLK_NS;
    typedef enum logic [2:0] {
        PPM_BATTLESS, PPM_STANDBY, PPM_SINK, PPM_SOURCE, PPM_SHUTDOWN
    } ppm_mode_t;
endpackage : ppm_pkg

// ### ppm_sync.sv
// two-flop synchroniser bank for asynchronous pins
// assumes the flops sit in the mclk_in domain
`timescale 1ns/1ns
`default_nettype none
module ppm_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_in,
    input  wire logic         sys_rst_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    if (W < 1) begin : g_bad_width
        $error("ppm_sync width must be at least one");
    end
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync;
    always_comb begin
        next_stage1 = async_in;
        next_sync   = stage1;
    end
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            stage1   <= '0;
            sync_out <= '0;
        end else if (ce_in) begin
            stage1   <= next_stage1;
            sync_out <= next_sync;
        end
    end
endmodule : ppm_sync
`default_nettype wire

// ### ppm_ctrl.sv
// mode controller for the port power-path switch
// assumes supply-valid levels and enable pins arrive asynchronously;
// the register port is a simple same-clock strobe interface
`timescale 1ns/1ns
`default_nettype none
module ppm_ctrl
    import ppm_pkg::*;
(
    // clock, reset, enable
    input  wire logic       mclk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       ce_in,
    // supply detectors (asynchronous)
    input  wire logic       bus_supply_ok_in,
    input  wire logic       chip_supply_ok_in,
    input  wire logic       five_volt_rail_ok_in,
    // control pins (asynchronous)
    input  wire logic       chip_disable_in,
    input  wire logic       sink_path_request_in,
    input  wire logic       source_path_request_in,
    input  wire logic       fast_swap_request_pin_in,
    // register port
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    // switches and status
    output logic            hv_sink_switch_out,
    output logic            five_volt_source_switch_out,
    output logic            hv_source_switch_out,
    output logic            fast_turn_on_out,
    output logic      [2:0] overvoltage_lockout_code_out,
    output logic            standby_out,
    output logic            shutdown_out,
    output logic      [2:0] mode_out,
    // open-drain alert: drive low when enabled
    output logic            alert_pin_out,
    output logic            alert_pin_oe_out
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [6:0] pins_s;
    ppm_sync #(.W(7)) u_sync (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .async_in   ({bus_supply_ok_in, chip_supply_ok_in, five_volt_rail_ok_in,
                      chip_disable_in, sink_path_request_in,
                      source_path_request_in, fast_swap_request_pin_in}),
        .sync_out   (pins_s)
    );
    logic bus_ok, chip_ok, rail_ok, dis, snk_req, src_req, swp_pin;
    assign {bus_ok, chip_ok, rail_ok, dis, snk_req, src_req, swp_pin} = pins_s;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ppm_mode_t  mode, next_mode;
    logic [7:0] src_choice_reg, next_src_choice_reg;
    logic [7:0] exit_swap_reg,  next_exit_swap_reg;
    logic [7:0] int_flags,      next_int_flags;
    logic       hv_sink_switch, next_hv_sink_switch;
    logic       src5, next_src5;
    logic       srchv, next_srchv;
    logic       fast, next_fast;
    logic [7:0] rdata, next_rdata;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    logic wr_exit, wr_src, wr_flags, leave_req, rd_flags;
    always_comb begin
        wr_exit   = reg_wr_in && hit(reg_addr_in, ADDR_EXIT_SWAP);
        wr_src    = reg_wr_in && hit(reg_addr_in, ADDR_SRC_CHOICE);
        wr_flags  = reg_wr_in && hit(reg_addr_in, ADDR_INT_FLAGS_A);
        rd_flags  = reg_rd_in && hit(reg_addr_in, ADDR_INT_FLAGS_A);
        leave_req = wr_exit && reg_wdata_in[BIT_LEAVE];
    end

    // ------------------------------------------------------------
    // mode and register next state
    // ------------------------------------------------------------
    logic set_fault, set_forbid, in_normal, exit_now;
    always_comb begin
        next_mode           = mode;
        next_src_choice_reg = src_choice_reg;
        next_exit_swap_reg  = exit_swap_reg;
        next_hv_sink_switch         = hv_sink_switch;
        next_src5           = src5;
        next_srchv          = srchv;
        next_fast           = 1'b0;
        set_fault           = 1'b0;
        set_forbid          = 1'b0;
        in_normal           = (mode != PPM_BATTLESS);
        // a valid chip supply with no port supply is normal mode as well
        exit_now            = !in_normal && chip_ok && (leave_req || !bus_ok);
        // registers stay writable in every mode
        if (wr_src) begin
            next_src_choice_reg = reg_wdata_in; // RL7
        end
        if (wr_exit) begin
            next_exit_swap_reg = reg_wdata_in;
            if (in_normal && !reg_wdata_in[BIT_LEAVE]) begin
                next_exit_swap_reg[BIT_LEAVE] = exit_swap_reg[BIT_LEAVE]; // RL10
            end
        end
        if (exit_now) begin
            // defaults restored; the pin decode below picks the mode at once
            next_src_choice_reg = RST_SRC_CHOICE;              // RL8
            next_exit_swap_reg  = RST_EXIT_SWAP;
            next_exit_swap_reg[BIT_LEAVE] = leave_req;         // RL4
            next_mode           = PPM_STANDBY;                 // RL12
            next_hv_sink_switch         = 1'b0;
            next_src5           = 1'b0;
            next_srchv          = 1'b0;
        end
        if (!in_normal && !exit_now) begin
            // pins and control bits ignored here
            next_hv_sink_switch = 1'b1;                                // RL2
            next_src5   = 1'b0;                                // RL6
            next_srchv  = 1'b0;                                // RL6
            set_fault   = leave_req;                           // RL5
        end else if (bus_ok && !chip_ok) begin
            next_mode = PPM_BATTLESS;                          // RL11
            next_exit_swap_reg[BIT_LEAVE] = 1'b0;              // RL11
            next_hv_sink_switch = 1'b1;                                // RL1
            next_src5   = 1'b0;
            next_srchv  = 1'b0;
        end else if (dis) begin
            next_mode   = PPM_SHUTDOWN;                        // RL20
            next_hv_sink_switch = 1'b0;
            next_src5   = 1'b0;
            next_srchv  = 1'b0;
        end else begin
            case ({snk_req, src_req})
                2'b00: begin
                    next_mode   = PPM_STANDBY;                 // RL19
                    next_hv_sink_switch = 1'b0;
                    next_src5   = 1'b0;
                    next_srchv  = 1'b0;
                end
                2'b10: begin
                    next_mode   = PPM_SINK;                    // RL13
                    next_hv_sink_switch = 1'b1;
                    next_src5   = 1'b0;
                    next_srchv  = 1'b0;
                end
                2'b01: begin
                    next_mode   = PPM_SOURCE;
                    next_hv_sink_switch = 1'b0;
                    if (next_src_choice_reg[BIT_SRC_CHOICE]) begin
                        next_src5  = 1'b0;
                        next_srchv = 1'b1;                     // RL15
                    end else begin
                        next_src5  = 1'b1;                     // RL14
                        next_srchv = 1'b0;
                    end
                    if ((swp_pin || next_exit_swap_reg[BIT_SWAP_ARM]) && rail_ok) begin
                        next_src5  = 1'b1;                     // RL17
                        next_srchv = 1'b0;
                        next_fast  = 1'b1;                     // RL17
                    end
                end
                default: begin
                    set_forbid = 1'b1;                         // RL16
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // flags: set wins over clear-on-write-one
    // ------------------------------------------------------------
    always_comb begin
        next_int_flags = int_flags;
        if (wr_flags) begin
            next_int_flags = int_flags & ~reg_wdata_in;
        end
        if (set_fault) begin
            next_int_flags[BIT_LEAVE_FAULT] = 1'b1;            // RL5
        end
        if (set_forbid) begin
            next_int_flags[BIT_FORBID_ERR] = 1'b1;             // RL16
        end
        next_rdata = rdata;
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_SRC_CHOICE:  next_rdata = src_choice_reg;
                ADDR_INT_FLAGS_A: next_rdata = int_flags;
                ADDR_EXIT_SWAP:   next_rdata = exit_swap_reg;
                default:          next_rdata = 8'h00;
            endcase
        end
        if (rd_flags) begin
            // clear on read, except events arriving now
            next_int_flags = 8'h00;                            // RL21
            next_int_flags[BIT_LEAVE_FAULT] = set_fault;
            next_int_flags[BIT_FORBID_ERR]  = set_forbid;
        end
    end

    // ------------------------------------------------------------
    // registers; flag register survives the restore on exit
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mode           <= PPM_BATTLESS;
            src_choice_reg <= RST_SRC_CHOICE;
            exit_swap_reg  <= RST_EXIT_SWAP;
            int_flags      <= RST_INT_FLAGS;
            hv_sink_switch         <= 1'b0;
            src5           <= 1'b0;
            srchv          <= 1'b0;
            fast           <= 1'b0;
            rdata          <= 8'h00;
        end else if (ce_in) begin
            mode           <= next_mode;
            src_choice_reg <= next_src_choice_reg;
            exit_swap_reg  <= next_exit_swap_reg;
            int_flags      <= next_int_flags;
            hv_sink_switch         <= next_hv_sink_switch;
            src5           <= next_src5;
            srchv          <= next_srchv;
            fast           <= next_fast;
            rdata          <= next_rdata;
        end
    end

    // outputs straight from flops
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            hv_sink_switch_out           <= 1'b0;
            five_volt_source_switch_out  <= 1'b0;
            hv_source_switch_out         <= 1'b0;
            fast_turn_on_out             <= 1'b0;
            overvoltage_lockout_code_out <= RST_OVERVOLTAGE_LOCKOUT_CODE;
            standby_out                  <= 1'b0;
            shutdown_out                 <= 1'b0;
            mode_out                     <= 3'h0;
            alert_pin_out                <= 1'b0;
            alert_pin_oe_out             <= 1'b0;
            reg_rdata_out                <= 8'h00;
        end else if (ce_in) begin
            hv_sink_switch_out           <= hv_sink_switch;
            five_volt_source_switch_out  <= src5;
            hv_source_switch_out         <= srchv;
            fast_turn_on_out             <= fast;
            // only the default code exists in this block
            overvoltage_lockout_code_out <= OVERVOLTAGE_LOCKOUT_CODE_6V8;     // RL3
            standby_out                  <= (mode == PPM_STANDBY);
            shutdown_out                 <= (mode == PPM_SHUTDOWN);
            mode_out                     <= mode;
            alert_pin_out                <= 1'b0;
            alert_pin_oe_out             <= |int_flags;        // RL18
            reg_rdata_out                <= rdata;
        end
    end
endmodule : ppm_ctrl
`default_nettype wire

// ### ppm_ctrl_checker.sv
// port-level assertions for the power-path mode controller
// assumes it is bound into ppm_ctrl and sees its ports only
`timescale 1ns/1ns
`default_nettype none
module ppm_ctrl_checker
    import ppm_pkg::*;
(
    // clock, reset, supplies, pins
    input wire logic       mclk_in,
    input wire logic       sys_rst_in,
    input wire logic       bus_supply_ok_in,
    input wire logic       chip_supply_ok_in,
    input wire logic       five_volt_rail_ok_in,
    input wire logic       chip_disable_in,
    input wire logic       sink_path_request_in,
    input wire logic       source_path_request_in,
    input wire logic       fast_swap_request_pin_in,
    // outputs under watch
    input wire logic       hv_sink_switch_out,
    input wire logic       five_volt_source_switch_out,
    input wire logic       hv_source_switch_out,
    input wire logic       fast_turn_on_out,
    input wire logic [2:0] overvoltage_lockout_code_out,
    input wire logic       standby_out,
    input wire logic       shutdown_out,
    input wire logic [2:0] mode_out
);
    // swap deadline in 100 ns cycles
    localparam int SWAP_CYC = SWAP_LIMIT_CYC;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    // ----
    // sequences
    // ----
    // eight cycles covers the pin synchroniser and output flop
    sequence s_dead;
        (bus_supply_ok_in && !chip_supply_ok_in)[*8];
    endsequence
    sequence s_pins(d, k, s);
        (chip_supply_ok_in && chip_disable_in == d && sink_path_request_in == k
            && source_path_request_in == s)[*8] ##0 mode_out != PPM_BATTLESS;
    endsequence
    sequence s_shut;
        (chip_supply_ok_in && chip_disable_in)[*8] ##0 mode_out != PPM_BATTLESS;
    endsequence
    sequence s_swap;
        $rose(fast_swap_request_pin_in) && five_volt_rail_ok_in && source_path_request_in
            && mode_out == PPM_SOURCE;
    endsequence
    // ----
    // assertions
    // ----
    AST_DEAD: assert property (s_dead |-> hv_sink_switch_out && !fast_turn_on_out
        && !five_volt_source_switch_out && !hv_source_switch_out && mode_out == PPM_BATTLESS)
        else $error("batteryless switches or mode wrong");
    AST_OVERVOLTAGE_LOCKOUT: assert property (mode_out == PPM_BATTLESS |->
        overvoltage_lockout_code_out == OVERVOLTAGE_LOCKOUT_CODE_6V8) else $error("lockout level not fixed");
    AST_LOSS: assert property ($fell(chip_supply_ok_in) && bus_supply_ok_in
        |-> ##[1:8] mode_out == PPM_BATTLESS) else $error("no return on supply loss");
    AST_SINK: assert property (s_pins(0, 1, 0) |-> hv_sink_switch_out && mode_out == PPM_SINK
        && !five_volt_source_switch_out && !hv_source_switch_out) else $error("sink mode wrong");
    AST_SRC: assert property (s_pins(0, 0, 1) |-> !hv_sink_switch_out
        && (five_volt_source_switch_out ^ hv_source_switch_out) && mode_out == PPM_SOURCE)
        else $error("source mode wrong");
    AST_STBY: assert property (s_pins(0, 0, 0) |-> standby_out && !hv_sink_switch_out
        && !five_volt_source_switch_out && !hv_source_switch_out) else $error("standby wrong");
    AST_SHUT: assert property (s_shut |-> shutdown_out && mode_out == PPM_SHUTDOWN
        && !hv_sink_switch_out && !five_volt_source_switch_out) else $error("shutdown wrong");
    AST_FORB: assert property (s_pins(0, 1, 1) |=> $stable({hv_sink_switch_out,
        five_volt_source_switch_out, hv_source_switch_out, mode_out}))
        else $error("forbidden pins changed state");
    AST_SWAP: assert property (s_swap |-> ##[1:SWAP_CYC] fast_turn_on_out
        && five_volt_source_switch_out) else $error("fast swap late");
endmodule : ppm_ctrl_checker
bind ppm_ctrl ppm_ctrl_checker u_chk (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .bus_supply_ok_in(bus_supply_ok_in),
    .chip_supply_ok_in(chip_supply_ok_in), .five_volt_rail_ok_in(five_volt_rail_ok_in),
    .chip_disable_in(chip_disable_in), .sink_path_request_in(sink_path_request_in),
    .source_path_request_in(source_path_request_in),
    .fast_swap_request_pin_in(fast_swap_request_pin_in),
    .hv_sink_switch_out(hv_sink_switch_out),
    .five_volt_source_switch_out(five_volt_source_switch_out),
    .hv_source_switch_out(hv_source_switch_out), .fast_turn_on_out(fast_turn_on_out),
    .overvoltage_lockout_code_out(overvoltage_lockout_code_out), .standby_out(standby_out),
    .shutdown_out(shutdown_out), .mode_out(mode_out)
);
`default_nettype wire

// ### ppm_host.sv
// host model on the register strobe port
// assumes strobes are taken on the rising clock edge
`timescale 1ns/1ns
`default_nettype none
module ppm_host (
    // clock
    input  wire logic       mclk_in,
    // register port
    input  wire logic [7:0] rdata_in,
    output logic            wr_out,
    output logic            rd_out,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out
);
    initial begin
        {wr_out, rd_out, addr_out, wdata_out} = 18'h0;
    end
    // released lines flip so a stale value never looks valid
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        {wr_out, addr_out, wdata_out} = {1'b1, a, d};
        @(negedge mclk_in);
        {wr_out, addr_out, wdata_out} = {1'b0, ~a, ~d};
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_in);
        {rd_out, addr_out} = {1'b1, a};
        @(negedge mclk_in);
        {rd_out, addr_out} = {1'b0, ~a};
        repeat (2) @(negedge mclk_in);
        d = rdata_in;
    endtask : rd
endmodule : ppm_host
`default_nettype wire

// ### power_path_mode_controller_bench.sv
// self-checking bench for the power-path mode controller
// assumes ppm_host on the register port; pins are driven here
`timescale 1ns/1ns
`default_nettype none
module power_path_mode_controller_bench
    import ppm_pkg::*;
;
    logic       clk = 1'b0, rst = 1'b1, bok = 1'b1, cok = 1'b0, rok = 1'b1;
    logic       dis = 1'b0, snk = 1'b0, src = 1'b0, fsp = 1'b0, ce = 1'b1, hwr, hrd;
    logic       sk_o, fv_o, hv_o, ft_o, sb_o, sd_o, al_o, oe_o;
    logic [2:0] ov_o, md_o;
    logic [7:0] ha, hd, rdat, r;
    int         fail_count = 0, cmp_count = 0, bl = 1, ch = 0, arm = 0, fl = 0, md = 0, sw = 4;
    ppm_host host (.mclk_in(clk), .rdata_in(rdat), .wr_out(hwr), .rd_out(hrd), .addr_out(ha),
        .wdata_out(hd));
    ppm_ctrl dut (.mclk_in(clk), .sys_rst_in(rst), .ce_in(ce), .bus_supply_ok_in(bok),
        .chip_supply_ok_in(cok), .five_volt_rail_ok_in(rok), .chip_disable_in(dis),
        .sink_path_request_in(snk), .source_path_request_in(src), .fast_swap_request_pin_in(fsp),
        .reg_wr_in(hwr), .reg_rd_in(hrd), .reg_addr_in(ha), .reg_wdata_in(hd),
        .reg_rdata_out(rdat), .hv_sink_switch_out(sk_o), .five_volt_source_switch_out(fv_o),
        .hv_source_switch_out(hv_o), .fast_turn_on_out(ft_o), .overvoltage_lockout_code_out(ov_o),
        .standby_out(sb_o), .shutdown_out(sd_o), .mode_out(md_o), .alert_pin_out(al_o),
        .alert_pin_oe_out(oe_o));
    initial forever #50 clk = ~clk;
    task close_out;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // ----
    // reference model, applied once the pins have settled
    // ----
    task step;
        logic [7:0] e;
        repeat (8) @(negedge clk);
        if (bl != 0) begin
            sw = 4;
            md = PPM_BATTLESS;
        end else if (dis) begin
            sw = 0;
            md = PPM_SHUTDOWN;
        end else if (snk && src) begin
            fl = fl | 2;
        end else begin
            sw = {snk, src && ch == 0, src && ch != 0};
            md = snk ? PPM_SINK : src ? PPM_SOURCE : PPM_STANDBY;
        end
        e = {sw[2:0], md == PPM_STANDBY, md == PPM_SHUTDOWN,
            bl == 0 && md == PPM_SOURCE && (fsp || arm != 0) && rok && ch == 0, fl != 0, 1'b0};
        chk({sk_o, fv_o, hv_o, sb_o, sd_o, ft_o, oe_o, al_o}, e);
        chk({5'h0, md_o}, md[7:0]);
        chk({5'h0, ov_o}, {5'h0, OVERVOLTAGE_LOCKOUT_CODE_6V8});
    endtask : step
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end
    initial begin
        void'($urandom(4));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        step();
        {src, fsp} = 2'b11;
        host.wr(ADDR_SRC_CHOICE, 8'h01);
        host.wr(ADDR_EXIT_SWAP, 8'h02);
        step();
        host.rd(ADDR_SRC_CHOICE, r);
        chk(r, 8'h01);
        host.wr(ADDR_EXIT_SWAP, 8'h03);
        fl = 1;
        step();
        host.wr(ADDR_EXIT_SWAP, 8'h00);
        {cok, src, fsp, snk} = 4'b1001;
        step();
        repeat (510) @(negedge clk);
        host.wr(ADDR_EXIT_SWAP, 8'h01);
        bl = 0;
        step();
        host.rd(ADDR_SRC_CHOICE, r);
        chk(r, RST_SRC_CHOICE);
        host.rd(ADDR_INT_FLAGS_A, r);
        chk(r, 8'h01);
        fl = 0;
        host.wr(ADDR_EXIT_SWAP, 8'h00);
        host.rd(ADDR_EXIT_SWAP, r);
        chk(r, 8'h01);
        host.rd(8'h55, r);
        chk(r, 8'h00);
        src = 1'b1;
        step();
        for (int i = 0; i < 24; i++) begin
            ch = $urandom % 2;
            {dis, snk, src, rok} = 4'($urandom);
            // pins settle first so a forbidden pair really freezes the old path
            repeat (2) @(negedge clk);
            host.wr(ADDR_SRC_CHOICE, ch[7:0]);
            step();
        end
        {dis, snk, src, rok} = 4'b0001;
        step();
        host.rd(ADDR_INT_FLAGS_A, r);
        chk(r, fl[7:0]);
        fl = 0;
        ch = 0;
        host.wr(ADDR_SRC_CHOICE, 8'h00);
        src = 1'b1;
        step();
        fsp = 1'b1;
        step();
        fsp = 1'b0;
        arm = 1;
        host.wr(ADDR_EXIT_SWAP, 8'h03);
        step();
        rok = 1'b0;
        step();
        // clock enable low freezes the source path although the request drops
        {ce, src} = 2'b00;
        repeat (6) @(negedge clk);
        chk({4'h0, fv_o, sb_o, ft_o, oe_o}, 8'h08);
        {ce, src} = 2'b11;
        cok = 1'b0;
        bl = 1;
        step();
        host.rd(ADDR_EXIT_SWAP, r);
        chk(r & 8'h01, 8'h00);
        {rst, bok, cok} = 3'b101;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        {bl, arm, fl} = {32'd0, 32'd0, 32'd0};
        step();
        close_out();
    end
endmodule : power_path_mode_controller_bench
`default_nettype wire
